/* src/alarm_evaluator.sv */
// alarm evaluation for the process controller alarm channels
`timescale 1ns/1ps
module alarm_evaluator
	import alarm_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SAMPLE,
	input wire alarm_pkg::val_t PROCESS_VALUE,
	input wire alarm_pkg::val_t SET_POINT,
	input wire alarm_pkg::val_t MV_HEAT,
	input wire alarm_pkg::val_t MV_COOL,
	input wire logic HEAT_COOL_MODE,
	input wire logic HEATER_OPTION,
	input wire logic ASSIGN_ALARM1,
	input wire logic HEATER_ALARM,
	input wire logic LOOP_BREAK_ALARM,
	input wire logic [NUM_ALARMS-1:0] RATE_ALARM,
	input wire logic [NUM_ALARMS-1:0] HYST_OVERLAP,
	input wire logic [NUM_ALARMS-1:0] TYPE_WE,
	input wire alarm_pkg::type_t TYPE_WDATA,
	input wire alarm_pkg::val_t THR_UPPER [NUM_ALARMS],
	input wire alarm_pkg::val_t THR_LOWER [NUM_ALARMS],
	input wire alarm_pkg::delay_t ON_DELAY [NUM_ALARMS],
	input wire alarm_pkg::delay_t OFF_DELAY [NUM_ALARMS],
	output logic [NUM_ALARMS-1:0] AUX_OUT,
	output logic [NUM_ALARMS-1:0] ALARM_RAW,
	output alarm_pkg::type_t TYPE_READ [NUM_ALARMS],
	output logic TYPE1_VISIBLE
);
	import alarm_pkg::*;

	// selector state and its next value
	type_t type_r [NUM_ALARMS];
	type_t type_nxt [NUM_ALARMS];

	// per-channel evaluation state
	logic [NUM_ALARMS-1:0] raw_r, raw_nxt;
	logic [NUM_ALARMS-1:0] armed_r, armed_nxt;
	logic [NUM_ALARMS-1:0] aux_r, aux_nxt;

	// channel one visibility under the heater variant
	logic vis_r, vis_nxt;

	// seconds divider feeding the delay counters
	logic tick_r, tick_nxt;
	logic [26:0] div_r, div_nxt;

	// unregistered conditions and delay stage results
	logic [NUM_ALARMS-1:0] cond_w, dly_out;

	// widened signed sum avoids wrap at range ends
	function automatic logic signed [VAL_W:0] add_s(input val_t a, input val_t b);
		add_s = {a[VAL_W-1], a} + {b[VAL_W-1], b};
	endfunction

	function automatic logic signed [VAL_W:0] sub_s(input val_t a, input val_t b);
		sub_s = {a[VAL_W-1], a} - {b[VAL_W-1], b};
	endfunction

	function automatic logic signed [VAL_W:0] ext_s(input val_t a);
		ext_s = {a[VAL_W-1], a};
	endfunction

	// cap a delay setting at the longest allowed time
	function automatic delay_t clamp_d(input delay_t d);
		clamp_d = (d > DELAY_MAX_S) ? DELAY_MAX_S : d;
	endfunction

	function automatic logic is_standby(input type_t t);
		is_standby = (t == TYPE_BAND_OUT_SB) || (t == TYPE_UPPER_SB) || (t == TYPE_LOWER_SB) ||
			(t == TYPE_ABS_HI_SB) || (t == TYPE_ABS_LO_SB);
	endfunction

	// map a standby type onto its plain counterpart
	function automatic type_t base_type(input type_t t);
		case (t)
			TYPE_BAND_OUT_SB: base_type = TYPE_BAND_OUT;
			TYPE_UPPER_SB: base_type = TYPE_UPPER;
			TYPE_LOWER_SB: base_type = TYPE_LOWER;
			TYPE_ABS_HI_SB: base_type = TYPE_ABS_HI;
			TYPE_ABS_LO_SB: base_type = TYPE_ABS_LO;
			default: base_type = t;
		endcase
	endfunction

	// raw alarm condition for one channel
	function automatic logic eval(input type_t t, input int ch, input val_t pv, input val_t sp,
		input val_t hi, input val_t lo, input val_t mvh, input val_t mvc, input logic hc,
		input logic loop_break_alarm, input logic rate, input logic ovl);
		logic signed [VAL_W:0] pv_x;
		logic signed [VAL_W:0] top_x;
		logic signed [VAL_W:0] bot_x;
		logic signed [VAL_W:0] dev_x;
		logic outside;
		// deviation edges carry one extra bit so the offset never wraps
		pv_x = ext_s(pv);
		top_x = add_s(sp, hi);
		bot_x = sub_s(sp, lo);
		dev_x = sub_s(sp, hi);
		outside = (pv_x > top_x) || (pv_x < bot_x);
		case (base_type(t))
			// disabled channel never raises
			TYPE_OFF: eval = 1'b0;

			// deviation types relative to the set point
			TYPE_BAND_OUT: eval = outside && !ovl;
			TYPE_UPPER: eval = pv_x >= top_x;
			TYPE_LOWER: eval = pv_x <= dev_x;
			TYPE_BAND_IN: eval = !outside && !ovl;

			// absolute process value limits, strict
			TYPE_ABS_HI: eval = pv > hi;
			TYPE_ABS_LO: eval = pv < hi;

			// results of algorithms outside this block
			TYPE_LOOP_BREAK: eval = (ch == 0) && loop_break_alarm;
			TYPE_RATE: eval = rate;

			// set point against its own threshold
			TYPE_SP_HI: eval = sp > hi;
			TYPE_SP_LO: eval = sp < hi;

			// manipulated variable; lower limit follows cooling side in heat/cool mode, heating side otherwise
			TYPE_MV_HI: eval = mvh > hi;
			TYPE_MV_LO: eval = hc ? (mvc < hi) : (mvh < hi);

			// codes above the table are refused at the write
			default: eval = 1'b0;
		endcase
	endfunction

	// type selectors: writes, range and channel checks
	always_comb
	begin
		for (int i = 0; i < NUM_ALARMS; i++)
		begin
			// hold unless a legal write reaches a visible channel
			type_nxt[i] = type_r[i];
			if (TYPE_WE[i] && TYPE_WDATA <= TYPE_MAX &&
				!(TYPE_WDATA == TYPE_LOOP_BREAK && i != 0) &&
				!(i == 0 && vis_r == 1'b0))
			begin
				type_nxt[i] = TYPE_WDATA;
			end
		end

		// selector stays hidden while heater alarm owns channel one
		vis_nxt = !HEATER_OPTION || ASSIGN_ALARM1;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < NUM_ALARMS; i++)
				type_r[i] <= TYPE_RESET;
			vis_r <= 1'b1;
		end
		else
		begin
			type_r <= type_nxt;
			vis_r <= vis_nxt;
		end
	end

	// one-second tick for the delay counters
	always_comb
	begin
		tick_nxt = 1'b0;
		div_nxt = div_r + 27'h0000001;
		// wrap once per second and pulse the tick
		if (div_r == 27'(SEC_CYCLES - 1))
		begin
			div_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			div_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	// per-sample evaluation with standby suppression
	always_comb
	begin
		raw_nxt = raw_r;
		armed_nxt = armed_r;
		for (int i = 0; i < NUM_ALARMS; i++)
		begin
			// condition from the selected type
			cond_w[i] = eval(type_r[i], i, PROCESS_VALUE, SET_POINT, THR_UPPER[i], THR_LOWER[i],
				MV_HEAT, MV_COOL, HEAT_COOL_MODE, LOOP_BREAK_ALARM, RATE_ALARM[i], HYST_OVERLAP[i]);

			// hidden channel one carries the heater alarm instead
			if (i == 0 && HEATER_OPTION && !vis_r)
			begin
				cond_w[i] = HEATER_ALARM;
			end

			// a new type restarts the standby wait; no result this cycle
			if (type_r[i] != type_nxt[i])
			begin
				armed_nxt[i] = 1'b0;
			end
			else if (SAMPLE)
			begin
				// condition seen false once releases standby
				if (!cond_w[i])
				begin
					armed_nxt[i] = 1'b1;
				end
				raw_nxt[i] = cond_w[i] && (!is_standby(type_r[i]) || armed_r[i]);
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			raw_r <= '0;
			armed_r <= '0;
		end
		else
		begin
			raw_r <= raw_nxt;
			armed_r <= armed_nxt;
		end
	end

	// delay stages, one per channel
	for (genvar g = 0; g < NUM_ALARMS; g++)
	begin : g_dly
		alarm_delay_if dif ();

		// raw result, sample strobe and seconds tick into the stage
		assign dif.cond = raw_r[g];
		assign dif.sample = SAMPLE;
		assign dif.sec_tick = tick_r;

		// delay settings above the limit clamp to it
		assign dif.on_delay = clamp_d(ON_DELAY[g]);
		assign dif.off_delay = clamp_d(OFF_DELAY[g]);
		assign dly_out[g] = dif.out;

		alarm_delay u_dly (
			.clk(CLK),
			.rst_n(RST_N),
			.dif(dif)
		);
	end

	// registered copy of delayed outputs
	always_comb
	begin
		aux_nxt = dly_out;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			aux_r <= '0;
		else
			aux_r <= aux_nxt;
	end

	// outputs straight from registers
	assign AUX_OUT = aux_r;
	assign ALARM_RAW = raw_r;
	assign TYPE_READ = type_r;
	assign TYPE1_VISIBLE = vis_r;
endmodule // alarm_evaluator

/* src/alarm_pkg.sv */
// constants and types shared by the alarm evaluator
package alarm_pkg;
	localparam int NUM_ALARMS = 3;
	localparam int VAL_W = 16;
	localparam int TYPE_W = 5;
	localparam int DELAY_W = 10;
	localparam logic [TYPE_W-1:0] TYPE_OFF = 5'h00;
	localparam logic [TYPE_W-1:0] TYPE_BAND_OUT = 5'h01;
	localparam logic [TYPE_W-1:0] TYPE_UPPER = 5'h02;
	localparam logic [TYPE_W-1:0] TYPE_LOWER = 5'h03;
	localparam logic [TYPE_W-1:0] TYPE_BAND_IN = 5'h04;
	localparam logic [TYPE_W-1:0] TYPE_BAND_OUT_SB = 5'h05;
	localparam logic [TYPE_W-1:0] TYPE_UPPER_SB = 5'h06;
	localparam logic [TYPE_W-1:0] TYPE_LOWER_SB = 5'h07;
	localparam logic [TYPE_W-1:0] TYPE_ABS_HI = 5'h08;
	localparam logic [TYPE_W-1:0] TYPE_ABS_LO = 5'h09;
	localparam logic [TYPE_W-1:0] TYPE_ABS_HI_SB = 5'h0A;
	localparam logic [TYPE_W-1:0] TYPE_ABS_LO_SB = 5'h0B;
	localparam logic [TYPE_W-1:0] TYPE_LOOP_BREAK = 5'h0C;
	localparam logic [TYPE_W-1:0] TYPE_RATE = 5'h0D;
	localparam logic [TYPE_W-1:0] TYPE_SP_HI = 5'h0E;
	localparam logic [TYPE_W-1:0] TYPE_SP_LO = 5'h0F;
	localparam logic [TYPE_W-1:0] TYPE_MV_HI = 5'h10;
	localparam logic [TYPE_W-1:0] TYPE_MV_LO = 5'h11;
	localparam logic [TYPE_W-1:0] TYPE_MAX = 5'h11;
	localparam logic [TYPE_W-1:0] TYPE_RESET = TYPE_UPPER;
	localparam logic [DELAY_W-1:0] DELAY_MAX_S = 10'h3E7;
	localparam int CLK_HZ = 125000000;
	localparam int SEC_S = 1;
	localparam int SEC_CYCLES = CLK_HZ * SEC_S;
	typedef logic signed [VAL_W-1:0] val_t;
	typedef logic [TYPE_W-1:0] type_t;
	typedef logic [DELAY_W-1:0] delay_t;
endpackage

/* src/alarm_delay_if.sv */
// condition and delay hand-off between evaluator and delay stage
`timescale 1ns/1ps
interface alarm_delay_if;
	import alarm_pkg::*;
	logic cond;
	logic sample;
	logic sec_tick;
	delay_t on_delay;
	delay_t off_delay;
	logic out;
	modport src (output cond, sample, sec_tick, on_delay, off_delay, input out);
	modport dly (input cond, sample, sec_tick, on_delay, off_delay, output out);
endinterface

/* src/alarm_delay.sv */
// on/off delay stage for one alarm channel
`timescale 1ns/1ps
module alarm_delay
	import alarm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	alarm_delay_if.dly dif
);
	logic out_r, out_nxt;
	delay_t cnt_r, cnt_nxt;

	// count seconds of stable opposite condition, then flip
	always_comb
	begin
		out_nxt = out_r;
		cnt_nxt = cnt_r;
		if (dif.sample)
		begin
			if (dif.cond == out_r)
				cnt_nxt = '0;
			else if (dif.cond && cnt_r >= dif.on_delay)
			begin
				out_nxt = 1'b1;
				cnt_nxt = '0;
			end
			else if (!dif.cond && cnt_r >= dif.off_delay)
			begin
				out_nxt = 1'b0;
				cnt_nxt = '0;
			end
		end
		if (dif.sec_tick && dif.cond != out_r && cnt_r < DELAY_MAX_S)
			cnt_nxt = cnt_r + 10'h001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_r <= 1'b0;
			cnt_r <= '0;
		end
		else
		begin
			out_r <= out_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign dif.out = out_r;
endmodule // alarm_delay

/* verification/alarm_evaluator_asserts.sv */
// port assertions for the alarm evaluator
`timescale 1ns/1ps
module alarm_evaluator_asserts
	import alarm_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SAMPLE,
	input wire alarm_pkg::val_t PROCESS_VALUE,
	input wire logic HEATER_OPTION,
	input wire logic ASSIGN_ALARM1,
	input wire logic [NUM_ALARMS-1:0] TYPE_WE,
	input wire alarm_pkg::type_t TYPE_WDATA,
	input wire alarm_pkg::val_t THR_UPPER [NUM_ALARMS],
	input wire logic [NUM_ALARMS-1:0] AUX_OUT,
	input wire logic [NUM_ALARMS-1:0] ALARM_RAW,
	input wire alarm_pkg::type_t TYPE_READ [NUM_ALARMS],
	input wire logic TYPE1_VISIBLE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// settled sample of channel one under a given type
	sequence abs_s;
		SAMPLE && !TYPE_WE[1] && $stable(TYPE_READ[1]) && TYPE_READ[1] == TYPE_ABS_HI;
	endsequence
	sequence off_s;
		SAMPLE && !TYPE_WE[1] && $stable(TYPE_READ[1]) && TYPE_READ[1] == TYPE_OFF;
	endsequence
	// evaluation, delay and selector checks
	raw_hold_a: assert property (!SAMPLE |=> $stable(ALARM_RAW[2:1])) else $error("raw moved");
	aux_hold_a: assert property ($changed(AUX_OUT) |-> $past(SAMPLE, 2)) else $error("aux moved");
	off_quiet_a: assert property (off_s |=> !ALARM_RAW[1]) else $error("off channel raised");
	abs_hi_a: assert property (abs_s |=> ALARM_RAW[1] == ($past(PROCESS_VALUE) > $past(THR_UPPER[1])))
		else $error("absolute compare wrong");
	range_refuse_a: assert property (TYPE_WE[1] && TYPE_WDATA > TYPE_MAX |=> $stable(TYPE_READ[1]))
		else $error("bad type taken");
	lb_channel_a: assert property (TYPE_WE[2] && TYPE_WDATA == TYPE_LOOP_BREAK |=> $stable(TYPE_READ[2]))
		else $error("loop break taken");
	type_accept_a: assert property (TYPE_WE[1] && TYPE_WDATA <= TYPE_MAX && TYPE_WDATA != TYPE_LOOP_BREAK
		|=> TYPE_READ[1] == $past(TYPE_WDATA)) else $error("type not taken");
	vis_a: assert property (1 |=> TYPE1_VISIBLE == (!$past(HEATER_OPTION) || $past(ASSIGN_ALARM1)))
		else $error("visibility wrong");
	hidden_refuse_a: assert property (TYPE_WE[0] && !TYPE1_VISIBLE |=> $stable(TYPE_READ[0]))
		else $error("hidden type taken");
endmodule // alarm_evaluator_asserts
bind alarm_evaluator alarm_evaluator_asserts i_alarm_evaluator_asserts (.*);

/* verification/loop_model.sv */
// sampling pulse source standing in for the control loop
`timescale 1ns/1ps
module loop_model #(parameter int PERIOD = 12)
(
	input wire logic clk,
	input wire logic rst_n,
	output logic sample
);
	int cnt;
	// one-cycle pulse each sampling period
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			sample <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			sample <= #1 (cnt == PERIOD - 1);
		end
	end
endmodule // loop_model

/* verification/alarm_evaluator_tb.sv */
// self-checking bench for the alarm evaluator
`timescale 1ns/1ps
`define CHK(nm, e, a) \
	begin \
		cmp_count++; \
		if ((a) !== (e)) \
		begin \
			n_fail++; \
			$display("Error %s exp %0h got %0h", nm, e, a); \
		end \
	end
module alarm_evaluator_tb;
	import alarm_pkg::*;
	logic clk = 0, rst_n = 0, sample, vis;
	logic hc = 0, hopt = 0, asg = 0, heat = 0, loop_break_alarm = 0;
	logic [NUM_ALARMS-1:0] rate = '0, ovl = '0, we = '0, aux, raw;
	type_t wd = '0;
	type_t trd [NUM_ALARMS];
	val_t pv = '0, sp = 16'sh0064, mvh = 16'sh000A, mvc = 16'sh0064;
	val_t thu [NUM_ALARMS] = '{default: 16'sh000A};
	val_t thl [NUM_ALARMS] = '{default: 16'sh000A};
	delay_t dz [NUM_ALARMS] = '{default: 10'h000};
	int n_fail = 0, cmp_count = 0;
	always #4 clk = ~clk;
	alarm_evaluator i_alarm_evaluator (.CLK(clk), .RST_N(rst_n), .SAMPLE(sample), .PROCESS_VALUE(pv),
		.SET_POINT(sp), .MV_HEAT(mvh), .MV_COOL(mvc), .HEAT_COOL_MODE(hc), .HEATER_OPTION(hopt),
		.ASSIGN_ALARM1(asg), .HEATER_ALARM(heat), .LOOP_BREAK_ALARM(loop_break_alarm), .RATE_ALARM(rate),
		.HYST_OVERLAP(ovl), .TYPE_WE(we), .TYPE_WDATA(wd), .THR_UPPER(thu), .THR_LOWER(thl),
		.ON_DELAY(dz), .OFF_DELAY(dz), .AUX_OUT(aux), .ALARM_RAW(raw), .TYPE_READ(trd), .TYPE1_VISIBLE(vis));
	loop_model i_loop_model (.clk(clk), .rst_n(rst_n), .sample(sample));
	// one type write, then one settling edge
	task automatic wr(input int ch, input type_t t);
		we[ch] = 1'b1;
		wd = t;
		@(posedge clk);
		#1 we[ch] = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic smp();
		@(posedge clk iff sample);
		#1;
	endtask
	// channel one: set type if new, apply values, judge raw
	task automatic cs(input type_t t, input val_t p, input val_t x, input logic e);
		if (trd[1] !== t)
			wr(1, t);
		pv = p;
		thu[1] = x;
		smp();
		smp();
		`CHK("raw", e, raw[1])
	endtask
	task automatic t_types();
		cs(TYPE_OFF, 16'sh7000, 16'sh000A, 1'b0);
		cs(TYPE_BAND_OUT, 16'sh006F, 16'sh000A, 1'b1);
		cs(TYPE_UPPER, 16'sh006E, 16'sh000A, 1'b1);
		cs(TYPE_UPPER, 16'sh006D, 16'sh000A, 1'b0);
		cs(TYPE_LOWER, 16'sh005A, 16'sh000A, 1'b1);
		cs(TYPE_BAND_IN, 16'sh0069, 16'sh000A, 1'b1);
		cs(TYPE_BAND_IN, 16'sh006F, 16'sh000A, 1'b0);
		cs(TYPE_ABS_HI, 16'sh0033, 16'sh0032, 1'b1);
		cs(TYPE_ABS_HI, 16'sh0032, 16'sh0032, 1'b0);
		cs(TYPE_ABS_LO, 16'sh0032, 16'sh0033, 1'b1);
		cs(TYPE_SP_HI, 16'sh0000, 16'sh0063, 1'b1);
		cs(TYPE_SP_LO, 16'sh0000, 16'sh0063, 1'b0);
		cs(TYPE_MV_HI, 16'sh0000, 16'sh0005, 1'b1);
		hc = 1'b1;
		cs(TYPE_MV_LO, 16'sh0000, 16'sh0014, 1'b0);
		hc = 1'b0;
		cs(TYPE_MV_LO, 16'sh0000, 16'sh0014, 1'b1);
		rate = 3'h2;
		cs(TYPE_RATE, 16'sh0000, 16'sh0014, 1'b1);
		rate = 3'h0;
	endtask
	// standby suppression and overlap blanking
	task automatic t_standby();
		cs(TYPE_UPPER_SB, 16'sh0078, 16'sh000A, 1'b0);
		cs(TYPE_UPPER_SB, 16'sh0064, 16'sh000A, 1'b0);
		cs(TYPE_UPPER_SB, 16'sh0078, 16'sh000A, 1'b1);
		ovl = 3'h2;
		cs(TYPE_BAND_OUT, 16'sh00C8, 16'sh000A, 1'b0);
		ovl = 3'h0;
		thl[1] = 16'sh0014;
		cs(TYPE_BAND_OUT, 16'sh0055, 16'sh000A, 1'b0);
		cs(TYPE_BAND_OUT, 16'sh004F, 16'sh000A, 1'b1);
		thl[1] = 16'sh000A;
	endtask
	// every code on channel two, bad codes refused
	task automatic t_codes();
		for (int t = 0; t <= 17; t++)
		begin
			wr(2, type_t'(t));
			`CHK("type", (t == 12) ? 5'h0B : type_t'(t), trd[2])
		end
		wr(2, 5'h12);
		`CHK("type", TYPE_MAX, trd[2])
		wr(0, TYPE_LOOP_BREAK);
		loop_break_alarm = 1'b1;
		smp();
		smp();
		`CHK("type", TYPE_LOOP_BREAK, trd[0])
		`CHK("raw", 1'b1, raw[0])
		loop_break_alarm = 1'b0;
	endtask
	// heater variant hides channel zero
	task automatic t_heater();
		hopt = 1'b1;
		heat = 1'b1;
		@(posedge clk);
		#1;
		wr(0, TYPE_LOWER);
		smp();
		smp();
		`CHK("vis", 1'b0, vis)
		`CHK("type", TYPE_LOOP_BREAK, trd[0])
		`CHK("raw", 1'b1, raw[0])
		asg = 1'b1;
		@(posedge clk);
		#1;
		`CHK("vis", 1'b1, vis)
	endtask
	// zero delays: aux follows raw one clock after the next sample
	task automatic t_aux();
		cs(TYPE_ABS_HI, 16'sh000A, 16'sh0000, 1'b1);
		smp();
		repeat (2) @(posedge clk);
		#1;
		`CHK("aux", 1'b1, aux[1])
		cs(TYPE_ABS_HI, 16'shFFF6, 16'sh0000, 1'b0);
		smp();
		repeat (2) @(posedge clk);
		#1;
		`CHK("aux", 1'b0, aux[1])
	endtask
	task automatic results();
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		foreach (trd[i]) `CHK("type", TYPE_RESET, trd[i])
		`CHK("aux", 3'h0, aux)
		t_types();
		t_standby();
		t_codes();
		t_aux();
		t_heater();
		results();
	end
	// watchdog
	initial
	begin
		repeat (30000) @(posedge clk);
		n_fail++;
		results();
	end
endmodule // alarm_evaluator_tb
